//--- design/erc_pin_sync.sv
// Two-stage synchroniser for the asynchronous target-board pins.
// Assumes the pins are unrelated to sys_clk.
module erc_pin_sync
  import erc_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   rst,
  input  wire logic   tgt_reset_n,
  input  wire logic   tgt_nmi_n,
  input  wire logic   tgt_hold_n,
  input  wire logic   tgt_rdy_n,
  input  wire logic   tgt_clk,
  erc_sync_if.src     sy
);

  logic [4:0] meta_reg;
  logic [4:0] meta_next;
  logic [4:0] sync_reg;
  logic [4:0] sync_next;

  always_comb begin
    meta_next = {tgt_clk, tgt_rdy_n, tgt_hold_n, tgt_nmi_n, tgt_reset_n};
    sync_next = meta_reg;
  end

  // Idle levels after reset keep the run logic from seeing false edges
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 5'h0F;
      sync_reg <= 5'h0F;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sy.rst_n_s  = sync_reg[0];
  assign sy.nmi_n_s  = sync_reg[1];
  assign sy.hold_n_s = sync_reg[2];
  assign sy.rdy_n_s  = sync_reg[3];
  assign sy.tclk_s   = sync_reg[4];

endmodule : erc_pin_sync

//--- design/erc_pkg.sv
// Constants shared by the run-control gating block and its input synchroniser.
// Assumes one clock, sys_clk at 125 MHz, and an active-high asynchronous reset.
package erc_pkg;

  // ----------------------------------------------------------------
  // Addresses and opcodes
  // ----------------------------------------------------------------
  localparam int          ERC_ADDR_W           = 20;
  localparam logic [19:0] ERC_VECTOR_ADDR      = 20'h0_0000;
  localparam logic [9:0]  ERC_PU_UPPER_ADDR    = 10'h3FD;
  localparam logic [9:0]  ERC_PU_LOWER_ADDR    = 10'h3FC;
  localparam int          ERC_PU_UPPER_BIT     = 1;
  localparam int          ERC_PU_LOWER_BIT     = 3;
  localparam logic [7:0]  ERC_BREAK_TRAP_OPCODE = 8'h00;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam int          ERC_SYNC_STAGES      = 2;
  localparam int          ERC_IRQ_W            = 6;
  localparam logic        ERC_RST_PIN_LVL      = 1'b1;
  localparam logic        ERC_NMI_PIN_LVL      = 1'b1;
  // Cycles of target-clock silence before it is judged stopped
  localparam int          ERC_EXT_TIMEOUT      = 16;

  typedef enum logic [1:0] {
    ERC_ST_HALTED,
    ERC_ST_RUNNING,
    ERC_ST_STEP_WAIT
  } erc_run_t;

endpackage : erc_pkg

//--- design/erc_run_ctl.sv
// Run-control and target-signal gating of an emulation pod.
// Assumes target pins are raw asynchronous inputs; host controls are on sys_clk.

module erc_run_ctl
  import erc_pkg::*;
#(
  parameter int IRQ_W = ERC_IRQ_W
)
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              tgt_reset_n,
  input  wire logic              tgt_nmi_n,
  input  wire logic              tgt_hold_n,
  input  wire logic              tgt_rdy_n,
  input  wire logic              tgt_clk,
  input  wire logic              host_go,
  input  wire logic              host_stop,
  input  wire logic              host_reset,
  input  wire logic              pod_reset_sw,
  input  wire logic              clk_sel_ext,
  input  wire logic              step_mode,
  input  wire logic              match_ret,
  input  wire logic              instr_done,
  input  wire logic [IRQ_W-1:0]  irq_req,
  input  wire logic [IRQ_W-1:0]  irq_en,
  input  wire logic              dma_req,
  input  wire logic              bus_rd,
  input  wire logic [19:0]       bus_addr,
  input  wire logic              int_ack,
  input  wire logic [7:0]        pu_reg_upper,
  input  wire logic [7:0]        pu_reg_lower,
  input  wire logic              sw_break_set,
  input  wire logic [7:0]        fetch_opcode,
  output logic                   run_state,
  output logic                   cpu_reset,
  output logic                   cpu_nmi,
  output logic                   cpu_clk_en,
  output logic                   periph_run,
  output logic [IRQ_W-1:0]       irq_pending,
  output logic                   irq_take,
  output logic [7:0]             vector_data,
  output logic [IRQ_W-1:0]       irq_clear,
  output logic                   alarm_led,
  output logic                   pu_ports_15_17,
  output logic                   dma_grant,
  output logic [7:0]             fetch_out,
  output logic                   hold_err
);

  erc_sync_if sy ();

  erc_pin_sync u_sync (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .tgt_reset_n (tgt_reset_n),
    .tgt_nmi_n   (tgt_nmi_n),
    .tgt_hold_n  (tgt_hold_n),
    .tgt_rdy_n   (tgt_rdy_n),
    .tgt_clk     (tgt_clk),
    .sy          (sy.src)
  );

  // Highest-priority enabled source: lowest index wins
  function automatic logic [IRQ_W-1:0] top_req(input logic [IRQ_W-1:0] v);
    logic [IRQ_W-1:0] r;
    r = '0;
    for (int i = IRQ_W - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction : top_req

  // ----------------------------------------------------------------
  // Run state
  // ----------------------------------------------------------------
  erc_run_t st_reg, st_next;
  logic     run_reg, run_next;
  logic     rstp_reg, rstp_next;
  logic     nmip_reg, nmip_next;
  logic     nmi_stop_reg, nmi_stop_next;
  logic     host_rst_reg, host_rst_next;
  logic     rel_pend_reg, rel_pend_next;
  logic     cpu_rst_reg, cpu_rst_next;
  logic     nmi_reg, nmi_next;
  logic     running;
  logic     rst_low;
  logic     nmi_low;

  assign running = (st_reg != ERC_ST_HALTED);
  assign rst_low = !sy.rst_n_s;
  assign nmi_low = !sy.nmi_n_s;

  always_comb begin
    st_next       = st_reg;
    rstp_next     = sy.rst_n_s;
    nmip_next     = sy.nmi_n_s;
    nmi_stop_next = nmi_stop_reg;
    host_rst_next = host_rst_reg;
    rel_pend_next = rel_pend_reg;
    cpu_rst_next  = host_reset;
    nmi_next      = 1'b0;
    unique case (st_reg)
      ERC_ST_HALTED: begin
        if (host_reset) begin
          host_rst_next = 1'b1;
        end
        if (host_go) begin
          st_next = step_mode ? ERC_ST_STEP_WAIT : ERC_ST_RUNNING;
          // Restart: host reset or NMI fallen during halt
          if (nmi_low && (host_rst_reg || nmi_stop_reg)) begin
            nmi_next = 1'b1;
          end
          host_rst_next = 1'b0;
        end
      end
      ERC_ST_RUNNING, ERC_ST_STEP_WAIT: begin
        nmi_stop_next = sy.nmi_n_s;
        cpu_rst_next  = host_reset || rst_low;
        if (rst_low) begin
          rel_pend_next = 1'b1;
        end
        if (nmip_reg && nmi_low && !rst_low) begin
          nmi_next = 1'b1;
        end
        // Release edge of the synced pin clears the pending release and re-raises NMI if it is low
        if (rel_pend_reg && !rstp_reg && !rst_low) begin
          rel_pend_next = 1'b0;
          nmi_next      = nmi_low;
        end
        if (host_stop) begin
          st_next = ERC_ST_HALTED;
        end else if (st_reg == ERC_ST_STEP_WAIT && match_ret && instr_done) begin
          st_next = ERC_ST_HALTED;
        end else if (st_reg == ERC_ST_RUNNING && step_mode && instr_done) begin
          st_next = ERC_ST_HALTED;
        end
      end
    endcase
    if (!(st_next != ERC_ST_HALTED)) begin
      rel_pend_next = 1'b0;
    end
    run_next = (st_next != ERC_ST_HALTED);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_reg       <= ERC_ST_HALTED;
      run_reg      <= 1'b0;
      rstp_reg     <= ERC_RST_PIN_LVL;
      nmip_reg     <= ERC_NMI_PIN_LVL;
      nmi_stop_reg <= ERC_NMI_PIN_LVL;
      host_rst_reg <= 1'b0;
      rel_pend_reg <= 1'b0;
      cpu_rst_reg  <= 1'b0;
      nmi_reg      <= 1'b0;
    end else begin
      st_reg       <= st_next;
      run_reg      <= run_next;
      rstp_reg     <= rstp_next;
      nmip_reg     <= nmip_next;
      nmi_stop_reg <= nmi_stop_next;
      host_rst_reg <= host_rst_next;
      rel_pend_reg <= rel_pend_next;
      cpu_rst_reg  <= cpu_rst_next;
      nmi_reg      <= nmi_next;
    end
  end

  // ----------------------------------------------------------------
  // Clock supply, interrupts, alarm, ports
  // ----------------------------------------------------------------
  logic             tclk_d_reg, tclk_d_next;
  logic [4:0]       tmo_reg, tmo_next;
  logic             clk_en_reg, clk_en_next;
  logic [IRQ_W-1:0] pend_reg, pend_next;
  logic             take_reg, take_next;
  logic [7:0]       vec_reg, vec_next;
  logic [IRQ_W-1:0] clr_reg, clr_next;
  logic             alarm_reg, alarm_next;
  logic             pu_reg, pu_next;
  logic             dma_reg, dma_next;
  logic [7:0]       fetch_reg, fetch_next;
  logic             herr_reg, herr_next;
  logic             prun_reg;
  logic             vec_rd;
  logic [IRQ_W-1:0] top;

  assign vec_rd = bus_rd && (bus_addr == ERC_VECTOR_ADDR);
  assign top    = top_req(irq_req & irq_en);

  always_comb begin
    tclk_d_next = sy.tclk_s;
    tmo_next    = (sy.tclk_s != tclk_d_reg) ? 5'h00 : tmo_reg;
    if (sy.tclk_s == tclk_d_reg && tmo_reg != 5'(ERC_EXT_TIMEOUT)) begin
      tmo_next = tmo_reg + 5'h01;
    end
    // Internal source ignores run state; external follows the target oscillator
    clk_en_next = !clk_sel_ext || (tmo_reg != 5'(ERC_EXT_TIMEOUT));
    // Requests while halted stay pending; only running lets one through
    pend_next = irq_req & irq_en;
    take_next = run_reg && (pend_next != '0);
    vec_next  = vec_reg;
    clr_next  = '0;
    if (vec_rd) begin
      clr_next = top;
      vec_next = '0;
      for (int i = 0; i < IRQ_W; i++) begin
        if (top[i]) begin
          vec_next = 8'(i);
        end
      end
    end
    alarm_next = alarm_reg;
    if (vec_rd && !int_ack) begin
      alarm_next = 1'b1;
    end else if (pod_reset_sw) begin
      alarm_next = 1'b0;
    end
    pu_next = pu_reg_upper[ERC_PU_UPPER_BIT]
           || pu_reg_lower[ERC_PU_LOWER_BIT];
    dma_next   = dma_req;
    fetch_next = sw_break_set ? ERC_BREAK_TRAP_OPCODE : fetch_opcode;
    // Flag hold/ready driven low while halted
    herr_next  = !run_reg && (!sy.hold_n_s || !sy.rdy_n_s);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tclk_d_reg <= 1'b0;
      tmo_reg    <= 5'h00;
      clk_en_reg <= 1'b1;
      pend_reg   <= '0;
      take_reg   <= 1'b0;
      vec_reg    <= 8'h00;
      clr_reg    <= '0;
      alarm_reg  <= 1'b0;
      pu_reg     <= 1'b0;
      dma_reg    <= 1'b0;
      fetch_reg  <= 8'h00;
      herr_reg   <= 1'b0;
    end else begin
      tclk_d_reg <= tclk_d_next;
      tmo_reg    <= tmo_next;
      clk_en_reg <= clk_en_next;
      pend_reg   <= pend_next;
      take_reg   <= take_next;
      vec_reg    <= vec_next;
      clr_reg    <= clr_next;
      alarm_reg  <= alarm_next;
      pu_reg     <= pu_next;
      dma_reg    <= dma_next;
      fetch_reg  <= fetch_next;
      herr_reg   <= herr_next;
    end
  end

  assign run_state      = run_reg;
  assign cpu_reset      = cpu_rst_reg;
  assign cpu_nmi        = nmi_reg;
  assign cpu_clk_en     = clk_en_reg;
  assign periph_run     = prun_reg;
  assign irq_pending    = pend_reg;
  assign irq_take       = take_reg;
  assign vector_data    = vec_reg;
  assign irq_clear      = clr_reg;
  assign alarm_led      = alarm_reg;
  assign pu_ports_15_17 = pu_reg;
  assign dma_grant      = dma_reg;
  assign fetch_out      = fetch_reg;
  assign hold_err       = herr_reg;

  // Peripherals never stop with the user program, only while rst is asserted
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prun_reg <= 1'b0;
    end else begin
      prun_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_halt_no_rst;
    @(posedge sys_clk) disable iff (rst) (!run_reg && !host_reset) |=> !cpu_reset;
  endproperty
  a_halt_no_rst: assert property (p_halt_no_rst) else $error("target reset passed while halted");

  property p_nmi_edge;
    @(posedge sys_clk) disable iff (rst)
      (running && st_next != ERC_ST_HALTED && nmip_reg && nmi_low && !rst_low) |=> cpu_nmi;
  endproperty
  a_nmi_edge: assert property (p_nmi_edge) else $error("nmi edge missed");

  property p_nmi_halted;
    @(posedge sys_clk) disable iff (rst) (!running && !host_go) |=> !cpu_nmi;
  endproperty
  a_nmi_halted: assert property (p_nmi_halted) else $error("nmi raised while halted");

  property p_no_take_halted;
    @(posedge sys_clk) disable iff (rst) !run_reg |=> !irq_take;
  endproperty
  a_no_take_halted: assert property (p_no_take_halted) else $error("interrupt taken while halted");

  sequence s_stray_read;
    vec_rd && !int_ack;
  endsequence
  property p_alarm;
    @(posedge sys_clk) disable iff (rst) s_stray_read |=> alarm_led;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not lit");

  property p_alarm_hold;
    @(posedge sys_clk) disable iff (rst) (alarm_led && !pod_reset_sw) |=> alarm_led;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped");

  property p_pullup;
    @(posedge sys_clk) disable iff (rst) pu_reg_upper[ERC_PU_UPPER_BIT] |=> pu_ports_15_17;
  endproperty
  a_pullup: assert property (p_pullup) else $error("upper pull-up ignored");

  property p_int_clk;
    @(posedge sys_clk) disable iff (rst) !clk_sel_ext |=> cpu_clk_en;
  endproperty
  a_int_clk: assert property (p_int_clk) else $error("internal clock gated");

  property p_break;
    @(posedge sys_clk) disable iff (rst) sw_break_set |=> fetch_out == ERC_BREAK_TRAP_OPCODE;
  endproperty
  a_break: assert property (p_break) else $error("break opcode not inserted");

  property p_clear;
    @(posedge sys_clk) disable iff (rst) vec_rd |=> irq_clear == $past(top);
  endproperty
  a_clear: assert property (p_clear) else $error("wrong request cleared");

endmodule : erc_run_ctl

//--- design/erc_sync_if.sv
// Interface carrying the synchronised target pins into the main block.
// Assumes both ends share sys_clk.
interface erc_sync_if;
  logic rst_n_s;
  logic nmi_n_s;
  logic hold_n_s;
  logic rdy_n_s;
  logic tclk_s;
  modport src (output rst_n_s, output nmi_n_s, output hold_n_s, output rdy_n_s, output tclk_s);
  modport dst (input rst_n_s, input nmi_n_s, input hold_n_s, input rdy_n_s, input tclk_s);
endinterface : erc_sync_if

//--- dv/emulator_run_control_gating_test.sv
// Self-checking bench for the run-control gating block.
// Assumes the target board model drives all target pins.
module emulator_run_control_gating_test;
  timeunit 1ns;
  timeprecision 100ps;
  import erc_pkg::*;
  logic sys_clk, rst, host_go, host_stop, host_reset, pod_reset_sw, clk_sel_ext, step_mode;
  logic match_ret, instr_done, dma_req, bus_rd, int_ack, sw_break_set;
  logic nmi_lvl, rst_lvl, osc_on, bad_hold;
  logic [ERC_IRQ_W-1:0] irq_req, irq_en, irq_pending, irq_clear;
  logic [19:0] bus_addr;
  logic [7:0] pu_reg_upper, pu_reg_lower, fetch_opcode, vector_data, fetch_out;
  logic tgt_reset_n, tgt_nmi_n, tgt_hold_n, tgt_rdy_n, tgt_clk;
  logic run_state, cpu_reset, cpu_nmi, cpu_clk_en, periph_run, irq_take, alarm_led;
  logic pu_ports_15_17, dma_grant, hold_err;
  int failures, checks, cycles, i, k;
  logic [7:0] nmi_q[$];
  logic [7:0] clr_q[$];

  erc_run_ctl u_erc_run_ctl (.sys_clk, .rst, .tgt_reset_n, .tgt_nmi_n, .tgt_hold_n, .tgt_rdy_n,
    .tgt_clk, .host_go, .host_stop, .host_reset, .pod_reset_sw, .clk_sel_ext, .step_mode,
    .match_ret, .instr_done, .irq_req, .irq_en, .dma_req, .bus_rd, .bus_addr, .int_ack,
    .pu_reg_upper, .pu_reg_lower, .sw_break_set, .fetch_opcode, .run_state, .cpu_reset,
    .cpu_nmi, .cpu_clk_en, .periph_run, .irq_pending, .irq_take, .vector_data, .irq_clear,
    .alarm_led, .pu_ports_15_17, .dma_grant, .fetch_out, .hold_err);

  erc_target_model u_erc_target_model (.run(run_state), .nmi_lvl, .rst_lvl, .osc_on, .bad_hold,
    .tgt_reset_n, .tgt_nmi_n, .tgt_hold_n, .tgt_rdy_n, .tgt_clk);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic tally_and_finish;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Anything still queued after the bounded wait never appeared
  task automatic drain;
    for (int j = 0; j < 16 && (nmi_q.size() + clr_q.size()) != 0; j++) cyc(1);
    while (nmi_q.size() != 0) cmp(8'h00, nmi_q.pop_front());
    while (clr_q.size() != 0) cmp(8'h00, clr_q.pop_front());
  endtask : drain

  task automatic go;
    host_go = 1'b1;
    cyc(1);
    host_go = 1'b0;
  endtask : go

  task automatic stop;
    host_stop = 1'b1;
    cyc(1);
    host_stop = 1'b0;
    cyc(2);
  endtask : stop

  task automatic vread(input logic ack, input logic [19:0] a);
    logic [ERC_IRQ_W-1:0] p;
    int                   idx;
    p = irq_req & irq_en;
    idx = 0;
    for (int j = ERC_IRQ_W - 1; j >= 0; j--) if (p[j]) idx = j;
    if (a == ERC_VECTOR_ADDR) clr_q.push_back(8'(p & (~p + 6'h01)));
    bus_rd = 1'b1;
    bus_addr = a;
    int_ack = ack;
    cyc(1);
    if (a == ERC_VECTOR_ADDR) cmp(vector_data, 8'(idx));
    bus_rd = 1'b0;
    int_ack = 1'b0;
    cyc(2);
  endtask : vread

  // --------------------------------------------------------------
  // Monitor: every pulse must match the oldest expectation
  // --------------------------------------------------------------
  always @(posedge sys_clk) begin
    #1;
    if (cpu_nmi === 1'b1) cmp(8'h01, nmi_q.size() != 0 ? nmi_q.pop_front() : 8'h00);
    if (irq_clear !== 6'h00) cmp(8'(irq_clear), clr_q.size() != 0 ? clr_q.pop_front() : 8'h00);
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish;
    end
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    {host_go, host_stop, host_reset, pod_reset_sw, clk_sel_ext, step_mode} = 6'h00;
    {match_ret, instr_done, dma_req, bus_rd, int_ack, sw_break_set, osc_on, bad_hold} = 8'h00;
    {irq_req, irq_en, bus_addr} = 32'h0000_0000;
    {pu_reg_upper, pu_reg_lower, fetch_opcode} = 24'h00_0000;
    rst = 1'b1;
    nmi_lvl = 1'b1;
    rst_lvl = 1'b1;
    failures = 0;
    checks = 0;
    cycles = 0;
    void'($urandom(50));
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    cyc(2);
    cmp(8'(run_state), 8'h00);
    cmp(8'(periph_run), 8'h01);
    go;
    cyc(1);
    cmp(8'(run_state), 8'h01);
    nmi_q.push_back(8'h01);
    nmi_lvl = 1'b0;
    drain;
    rst_lvl = 1'b0;
    cyc(6);
    cmp(8'(cpu_reset), 8'h01);
    nmi_q.push_back(8'h01);
    rst_lvl = 1'b1;
    drain;
    nmi_lvl = 1'b1;
    cyc(6);
    stop;
    cmp(8'(run_state), 8'h00);
    // Reset pin while halted must leave no trace; NMI fallen while halted fires on restart
    nmi_lvl = 1'b0;
    rst_lvl = 1'b0;
    cyc(8);
    cmp(8'(cpu_reset), 8'h00);
    rst_lvl = 1'b1;
    cyc(6);
    nmi_q.push_back(8'h01);
    go;
    drain;
    stop;
    go;
    cyc(8);
    stop;
    host_reset = 1'b1;
    cyc(1);
    host_reset = 1'b0;
    cyc(4);
    nmi_q.push_back(8'h01);
    go;
    drain;
    stop;
    nmi_lvl = 1'b1;
    irq_en = 6'h3F;
    irq_req = 6'($urandom) | 6'h01;
    cyc(6);
    cmp(8'(irq_take), 8'h00);
    cmp(8'(irq_pending), 8'(irq_req & irq_en));
    go;
    for (i = 0; i < 8 && irq_take !== 1'b1; i++) cyc(1);
    cmp(8'(irq_take), 8'h01);
    stop;
    // Step onto a match: only the returned instruction ends the step
    step_mode = 1'b1;
    go;
    cmp(8'(run_state), 8'h01);
    match_ret = 1'b1;
    cyc(2);
    cmp(8'(run_state), 8'h01);
    instr_done = 1'b1;
    cyc(1);
    {match_ret, instr_done, step_mode} = 3'h0;
    cyc(1);
    cmp(8'(run_state), 8'h00);
    irq_en = 6'($urandom) | 6'h20;
    irq_req = 6'($urandom) | 6'h20;
    vread(1'b1, ERC_VECTOR_ADDR);
    cmp(8'(alarm_led), 8'h00);
    vread(1'b0, 20'h0_0001);
    cmp(8'(alarm_led), 8'h00);
    vread(1'b0, ERC_VECTOR_ADDR);
    cmp(8'(alarm_led), 8'h01);
    drain;
    pod_reset_sw = 1'b1;
    cyc(1);
    pod_reset_sw = 1'b0;
    cyc(2);
    cmp(8'(alarm_led), 8'h00);
    irq_req = 6'h00;
    cyc(30);
    cmp(8'(cpu_clk_en), 8'h01);
    clk_sel_ext = 1'b1;
    for (k = 1; k < 4; k++) begin
      osc_on = k[0];
      cyc(30);
      cmp(8'(cpu_clk_en), 8'(k[0]));
    end
    clk_sel_ext = 1'b0;
    for (k = 0; k < 4; k++) begin
      pu_reg_upper = (8'($urandom) & 8'hFD) | {6'h00, k[1], 1'b0};
      pu_reg_lower = (8'($urandom) & 8'hF7) | {4'h0, k[0], 3'h0};
      cyc(2);
      cmp(8'(pu_ports_15_17), 8'(k[1] | k[0]));
    end
    for (k = 0; k < 2; k++) begin
      sw_break_set = k[0];
      fetch_opcode = 8'($urandom) | 8'h01;
      cyc(2);
      cmp(fetch_out, k[0] ? ERC_BREAK_TRAP_OPCODE : fetch_opcode);
    end
    dma_req = 1'b1;
    cyc(3);
    cmp(8'(dma_grant), 8'h01);
    dma_req = 1'b0;
    bad_hold = 1'b1;
    cyc(5);
    cmp(8'(hold_err), 8'h01);
    cmp(8'(dma_grant), 8'h00);
    bad_hold = 1'b0;
    cyc(5);
    cmp(8'(hold_err), 8'h00);
    cmp(8'(periph_run), 8'h01);
    drain;
    tally_and_finish;
  end
endmodule : emulator_run_control_gating_test

//--- dv/erc_target_model.sv
// Target board model: reset, NMI, hold, ready and oscillator pins.
// Assumes the bench sets the pin levels and feeds back the pod run state.
module erc_target_model (
  input  wire logic run,
  input  wire logic nmi_lvl,
  input  wire logic rst_lvl,
  input  wire logic osc_on,
  input  wire logic bad_hold,
  output logic      tgt_reset_n,
  output logic      tgt_nmi_n,
  output logic      tgt_hold_n,
  output logic      tgt_rdy_n,
  output logic      tgt_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  assign tgt_reset_n = rst_lvl;
  assign tgt_nmi_n   = nmi_lvl;
  // Held low only while running; bad_hold injects the fault case
  assign tgt_hold_n  = run ? 1'b0 : !bad_hold;
  assign tgt_rdy_n   = run ? 1'b0 : !bad_hold;
  // Oscillator stands still when off, phase unrelated to sys_clk
  initial begin
    tgt_clk = 1'b0;
    forever #10.3 if (osc_on) tgt_clk = ~tgt_clk;
  end
endmodule : erc_target_model
